// ---- lxc_pkg.sv ----
// Constants for the low-frequency and external oscillator control block.
// Assumes an 8-bit special-function register bus on the system clock.
package lxc_pkg;
    // Register addresses
    localparam logic [7:0] LXC_ADDR_LFO = 8'h86;
    localparam logic [7:0] LXC_ADDR_XOSC = 8'hb1;
    // Low-frequency control register fields
    localparam int LXC_LFO_EN_BIT = 7;
    localparam int LXC_LFO_RDY_BIT = 6;
    localparam int LXC_LFO_FT_LSB = 2;
    localparam int LXC_LFO_FT_MSB = 5;
    localparam int LXC_LFO_DIV_LSB = 0;
    localparam int LXC_LFO_DIV_MSB = 1;
    // External control register fields
    localparam int LXC_XOSC_VLD_BIT = 7;
    localparam int LXC_XOSC_MODE_LSB = 4;
    localparam int LXC_XOSC_MODE_MSB = 6;
    localparam int LXC_XOSC_FREQ_LSB = 0;
    localparam int LXC_XOSC_FREQ_MSB = 2;
    // Reset values
    localparam logic [3:0] LXC_FT_RESET = 4'h8;
    localparam logic [1:0] LXC_DIV_RESET = 2'h0;
    localparam logic [2:0] LXC_MODE_RESET = 3'h0;
    localparam logic [2:0] LXC_FREQ_RESET = 3'h0;
    localparam logic [7:0] LXC_RDATA_RESET = 8'h00;
    // Divider select codes
    localparam logic [1:0] LXC_DIV8 = 2'h0;
    localparam logic [1:0] LXC_DIV4 = 2'h1;
    localparam logic [1:0] LXC_DIV2 = 2'h2;
    localparam logic [1:0] LXC_DIV1 = 2'h3;
    // Oscillator rising edges per half period of the divided output, less one
    localparam logic [1:0] LXC_HALF8_LAST = 2'h3;
    localparam logic [1:0] LXC_HALF4_LAST = 2'h1;
    localparam logic [1:0] LXC_HALF2_LAST = 2'h0;
    // External mode codes
    localparam logic [2:0] LXC_MODE_OFF0 = 3'h0;
    localparam logic [2:0] LXC_MODE_OFF1 = 3'h1;
    localparam logic [2:0] LXC_MODE_CMOS = 3'h2;
    localparam logic [2:0] LXC_MODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] LXC_MODE_RC_DIV2 = 3'h4;
    localparam logic [2:0] LXC_MODE_CAP_DIV2 = 3'h5;
    localparam logic [2:0] LXC_MODE_XTAL = 3'h6;
    localparam logic [2:0] LXC_MODE_XTAL_DIV2 = 3'h7;
    localparam int LXC_NUM_TIMERS = 2;
    localparam int LXC_TIMER_W = 16;
endpackage : lxc_pkg

// ---- lxc_lfo_if.sv ----
// Signals between the control top and the low-frequency divider.
// Both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface lxc_lfo_if;
    logic enable;
    logic [1:0] div_sel;
    logic osc_sync;
    logic div_clk;
    logic rise;
    logic fall;
    modport ctrl (output enable, output div_sel, output osc_sync,
                  input div_clk, input rise, input fall);
    modport div (input enable, input div_sel, input osc_sync,
                 output div_clk, output rise, output fall);
endinterface : lxc_lfo_if
`default_nettype wire

// ---- lxc_lfo_div.sv ----
// Divider for the synchronised low-frequency oscillator, with edge pulses.
// Assumes osc_sync is already synchronised to clk and far slower than clk.
`timescale 1ns/10ps
`default_nettype none
module lxc_lfo_div (
    input wire logic clk,
    input wire logic rst_n,
    lxc_lfo_if.div lfo
);
    logic [1:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic prev_q, prev_d;
    logic rise_d;
    logic fall_d;
    logic [1:0] last;
    logic osc_edge;

    always_comb begin
        case (lfo.div_sel) // RULE4
            lxc_pkg::LXC_DIV8: last = lxc_pkg::LXC_HALF8_LAST;
            lxc_pkg::LXC_DIV4: last = lxc_pkg::LXC_HALF4_LAST;
            default: last = lxc_pkg::LXC_HALF2_LAST;
        endcase
        osc_edge = lfo.osc_sync & ~prev_q;
        prev_d = lfo.osc_sync;
        cnt_d = cnt_q;
        out_d = out_q;
        if (!lfo.enable) begin
            // Idle low and restart the count so re-enable begins cleanly
            cnt_d = 2'h0; // RULE15
            out_d = 1'b0; // RULE15
        end else if (lfo.div_sel == lxc_pkg::LXC_DIV1) begin
            cnt_d = 2'h0;
            out_d = lfo.osc_sync; // RULE4
        end else if (osc_edge) begin
            if (cnt_q >= last) begin
                cnt_d = 2'h0;
                out_d = ~out_q; // RULE4
            end else begin
                cnt_d = cnt_q + 2'h1;
            end
        end
        rise_d = out_d & ~out_q;
        fall_d = ~out_d & out_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            out_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
            prev_q <= prev_d;
        end
    end

    assign lfo.div_clk = out_q;
    // Edge pulses leave with the next output level, so a registered
    // capture upstream lands in the cycle the divided clock shows the edge
    assign lfo.rise = rise_d;
    assign lfo.fall = fall_d;

    a_div_idle_low: assert property (@(posedge clk) // RULE15
        disable iff (!rst_n)
        !lfo.enable |=> !out_q)
        else $error("divided clock active while disabled");
    a_div1_follow: assert property (@(posedge clk) // RULE4
        disable iff (!rst_n)
        (lfo.enable && lfo.div_sel == lxc_pkg::LXC_DIV1) |=>
        out_q == $past(lfo.osc_sync))
        else $error("divide by one does not follow oscillator");
    a_div8_hold: assert property (@(posedge clk) // RULE4
        disable iff (!rst_n)
        (lfo.enable && lfo.div_sel == lxc_pkg::LXC_DIV8 && osc_edge &&
         cnt_q == 2'h0) |=> $stable(out_q) && cnt_q == 2'h1)
        else $error("divide by eight toggled too early");
endmodule : lxc_lfo_div
`default_nettype wire

// ---- lxc_top.sv ----
// Low-frequency oscillator and external oscillator control registers.
// Assumes an 8-bit register port on clk; analog status inputs are async.
// Overview of operation
// (RULE1) Oscillator enable output follows bit 7 of the low-frequency register.
// (RULE2) Bit 6 reads one once the oscillator frequency has stabilised.
// (RULE3) Ready clears only on reset or a change of the divider field.
// (RULE4) Divider field 00,01,10,11 divides the oscillator by 8,4,2,1.
// (RULE5) Bits 5:2 hold fine tune; 0000 fastest, 1111 slowest.
// (RULE6) Firmware should change fine tune only while the oscillator is off.
// (RULE7) Capture on falling output edge for timer 2, rising for timer 3.
// (RULE8) A capture copies the timer count into its reload bytes.
// (RULE9) Software derives period from two captures and adjusts fine tune.
// (RULE10) External bit 7 reads one when the oscillator runs and is stable.
// (RULE11) Both CMOS clock modes always read the valid flag as zero.
// (RULE12) Mode 00x is off, 010 CMOS clock, 011 CMOS clock divided by 2.
// (RULE13) Modes 100 RC/2, 101 capacitor/2, 110 crystal, 111 crystal/2.
// (RULE14) Bits 2:0 of the external register hold the frequency control.
// (RULE15) Divided output idles low while disabled and resumes on re-enable.
`timescale 1ns/10ps
`default_nettype none
module lxc_top #(
    parameter logic [3:0] FT_RESET = lxc_pkg::LXC_FT_RESET
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic lfo_osc_in,
    input wire logic lfo_stable_in,
    input wire logic xosc_stable_in,
    output logic lfo_enable,
    output logic [3:0] lfo_fine_tune,
    output logic lfo_divided_clk,
    output logic [2:0] xosc_mode,
    output logic [2:0] xosc_freq_ctl,
    input wire logic [1:0] timer_capture_mode,
    input wire logic [31:0] timer_count,
    output logic [1:0] timer_capture,
    output logic [31:0] timer_reload
);
    lxc_lfo_if lfo ();

    logic [2:0] sync1_q, sync2_q;
    logic en_q, en_d;
    logic rdy_q, rdy_d;
    logic [3:0] ft_q, ft_d;
    logic [1:0] div_q, div_d;
    logic [2:0] mode_q, mode_d;
    logic [2:0] freq_q, freq_d;
    logic vld_q, vld_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] cap_q, cap_d;
    logic [31:0] rel_q, rel_d;
    logic wr_lfo, wr_xosc;
    logic [1:0] new_div;
    logic [1:0] cap_edge;

    // Analog outputs are asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {xosc_stable_in, lfo_stable_in, lfo_osc_in};
            sync2_q <= sync1_q;
        end
    end

    assign lfo.enable = en_q;
    assign lfo.div_sel = div_q;
    assign lfo.osc_sync = sync2_q[0];

    lxc_lfo_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .lfo(lfo)
    );

    always_comb begin
        wr_lfo = sfr_wr && sfr_addr == lxc_pkg::LXC_ADDR_LFO;
        wr_xosc = sfr_wr && sfr_addr == lxc_pkg::LXC_ADDR_XOSC;
        new_div = sfr_wdata[lxc_pkg::LXC_LFO_DIV_MSB:lxc_pkg::LXC_LFO_DIV_LSB];
        en_d = en_q;
        ft_d = ft_q;
        div_d = div_q;
        mode_d = mode_q;
        freq_d = freq_q;
        if (wr_lfo) begin
            en_d = sfr_wdata[lxc_pkg::LXC_LFO_EN_BIT]; // RULE1
            ft_d = sfr_wdata[lxc_pkg::LXC_LFO_FT_MSB:lxc_pkg::LXC_LFO_FT_LSB]; // RULE5
            div_d = new_div; // RULE4
        end
        if (wr_xosc) begin
            mode_d = sfr_wdata[lxc_pkg::LXC_XOSC_MODE_MSB:
                               lxc_pkg::LXC_XOSC_MODE_LSB]; // RULE12
            freq_d = sfr_wdata[lxc_pkg::LXC_XOSC_FREQ_MSB:
                               lxc_pkg::LXC_XOSC_FREQ_LSB]; // RULE14
        end
        // A divider change restarts stabilisation, so the clear wins
        if (wr_lfo && new_div != div_q)
            rdy_d = 1'b0; // RULE3
        else
            rdy_d = rdy_q | (en_q & sync2_q[1]); // RULE2
        case (mode_q)
            lxc_pkg::LXC_MODE_RC_DIV2, lxc_pkg::LXC_MODE_CAP_DIV2,
            lxc_pkg::LXC_MODE_XTAL, lxc_pkg::LXC_MODE_XTAL_DIV2:
                vld_d = sync2_q[2]; // RULE13 RULE10
            default: vld_d = 1'b0; // RULE11 RULE12
        endcase
        rdata_d = rdata_q;
        if (sfr_rd) begin
            if (sfr_addr == lxc_pkg::LXC_ADDR_LFO)
                rdata_d = {en_q, rdy_q, ft_q, div_q}; // RULE2
            else if (sfr_addr == lxc_pkg::LXC_ADDR_XOSC)
                rdata_d = {vld_q, mode_q, 1'b0, freq_q}; // RULE10
            else
                rdata_d = lxc_pkg::LXC_RDATA_RESET;
        end
    end

    // Timer 2 takes falling edges, timer 3 rising edges
    // Pulses come from the divider's next state, so capture meets its edge
    assign cap_edge = {lfo.rise, lfo.fall}; // RULE7

    genvar gi;
    generate
        for (gi = 0; gi < lxc_pkg::LXC_NUM_TIMERS; gi++) begin : g_cap
            always_comb begin
                cap_d[gi] = timer_capture_mode[gi] & cap_edge[gi]; // RULE7
                rel_d[gi*lxc_pkg::LXC_TIMER_W +: lxc_pkg::LXC_TIMER_W] =
                    cap_d[gi] ?
                    timer_count[gi*lxc_pkg::LXC_TIMER_W +:
                                lxc_pkg::LXC_TIMER_W] :
                    rel_q[gi*lxc_pkg::LXC_TIMER_W +:
                          lxc_pkg::LXC_TIMER_W]; // RULE8
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            rdy_q <= 1'b0;
            ft_q <= FT_RESET;
            div_q <= lxc_pkg::LXC_DIV_RESET;
            mode_q <= lxc_pkg::LXC_MODE_RESET;
            freq_q <= lxc_pkg::LXC_FREQ_RESET;
            vld_q <= 1'b0;
            rdata_q <= lxc_pkg::LXC_RDATA_RESET;
            cap_q <= 2'h0;
            rel_q <= 32'h0;
        end else begin
            en_q <= en_d;
            rdy_q <= rdy_d;
            ft_q <= ft_d;
            div_q <= div_d;
            mode_q <= mode_d;
            freq_q <= freq_d;
            vld_q <= vld_d;
            rdata_q <= rdata_d;
            cap_q <= cap_d;
            rel_q <= rel_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign lfo_enable = en_q;
    assign lfo_fine_tune = ft_q;
    assign lfo_divided_clk = lfo.div_clk;
    assign xosc_mode = mode_q;
    assign xosc_freq_ctl = freq_q;
    assign timer_capture = cap_q;
    assign timer_reload = rel_q;

    a_enable_write: assert property (@(posedge clk) // RULE1
        disable iff (!rst_n)
        wr_lfo |=> lfo_enable == $past(sfr_wdata[lxc_pkg::LXC_LFO_EN_BIT]))
        else $error("enable did not take written bit");
    a_ready_div_clear: assert property (@(posedge clk) // RULE3
        disable iff (!rst_n)
        (wr_lfo && new_div != div_q) |=> !rdy_q)
        else $error("ready not cleared by divider change");
    a_ready_sticky: assert property (@(posedge clk) // RULE3
        disable iff (!rst_n)
        (rdy_q && !(wr_lfo && new_div != div_q)) |=> rdy_q)
        else $error("ready cleared without cause");
    a_ready_sets: assert property (@(posedge clk) // RULE2
        disable iff (!rst_n)
        (en_q && sync2_q[1] && !wr_lfo) |=> rdy_q)
        else $error("ready not set when stable");
    a_cmos_valid_zero: assert property (@(posedge clk) // RULE11
        disable iff (!rst_n)
        (mode_q == lxc_pkg::LXC_MODE_CMOS ||
         mode_q == lxc_pkg::LXC_MODE_CMOS_DIV2) |=> !vld_q)
        else $error("valid flag set in CMOS mode");
    a_off_valid_zero: assert property (@(posedge clk) // RULE12
        disable iff (!rst_n)
        (mode_q == lxc_pkg::LXC_MODE_OFF0 ||
         mode_q == lxc_pkg::LXC_MODE_OFF1) |=> !vld_q)
        else $error("valid flag set while off");
    a_valid_follows: assert property (@(posedge clk) // RULE10
        disable iff (!rst_n)
        (mode_q >= lxc_pkg::LXC_MODE_RC_DIV2) |=>
        vld_q == $past(sync2_q[2]))
        else $error("valid flag does not follow oscillator status");
    a_t2_fall_capture: assert property (@(posedge clk) // RULE7
        disable iff (!rst_n)
        timer_capture[0] |-> $fell(lfo_divided_clk))
        else $error("timer 2 captured off a falling edge");
    a_t3_rise_capture: assert property (@(posedge clk) // RULE7
        disable iff (!rst_n)
        timer_capture[1] |-> $rose(lfo_divided_clk))
        else $error("timer 3 captured off a rising edge");
    a_capture_copy: assert property (@(posedge clk) // RULE8
        disable iff (!rst_n)
        (timer_capture_mode[1] && lfo.rise) |=>
        timer_capture[1] && timer_reload[31:16] == $past(timer_count[31:16]))
        else $error("timer 3 capture did not copy count");
    a_reload_hold: assert property (@(posedge clk) // RULE8
        disable iff (!rst_n)
        (timer_capture == 2'h0) |-> $stable(timer_reload))
        else $error("reload changed without a capture");
    a_lfo_readback: assert property (@(posedge clk) // RULE5
        disable iff (!rst_n)
        (sfr_rd && sfr_addr == lxc_pkg::LXC_ADDR_LFO) |=>
        sfr_rdata[lxc_pkg::LXC_LFO_FT_MSB:lxc_pkg::LXC_LFO_FT_LSB] ==
        $past(lfo_fine_tune))
        else $error("fine tune readback wrong");
endmodule : lxc_top
`default_nettype wire

// ---- lxc_osc_model.sv ----
// Behavioural model of the low-frequency oscillator and its settle detector.
// Assumes enable comes from a register clocked on the 5 ns system clock.
`timescale 1ns/10ps
`default_nettype none
module lxc_osc_model #(
    parameter int HALF_NS = 40,
    parameter int SETTLE_NS = 300
) (
    input wire logic enable,
    input wire logic settle_ok,
    output logic osc_out,
    output logic stable
);
    logic settled;
    logic osc_q;
    // The 2 ns offset keeps edges off clk edges; the output is gated at
    // once on disable, since the free-running loop only notices it later
    always begin
        osc_q = 1'b0;
        wait (enable === 1'b1);
        #2;
        while (enable === 1'b1) begin
            #HALF_NS;
            osc_q = ~osc_q;
        end
    end
    assign osc_out = osc_q & (enable === 1'b1);
    always begin
        settled = 1'b0;
        wait (enable === 1'b1);
        #SETTLE_NS;
        settled = 1'b1;
        wait (enable !== 1'b1);
    end
    // Bench may withdraw the settled level to show ready is sticky
    assign stable = settled & settle_ok;
endmodule : lxc_osc_model
`default_nettype wire

// ---- lxc_top_tb.sv ----
// Self-checking bench for the oscillator control registers.
// Assumes lxc_top with its one-cycle register port and the oscillator model.
`timescale 1ns/10ps
`default_nettype none
module lxc_top_tb;
    localparam logic [7:0] LFO = lxc_pkg::LXC_ADDR_LFO;
    localparam logic [7:0] XOSC = lxc_pkg::LXC_ADDR_XOSC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic settle_ok = 1'b1;
    logic xosc_stable = 1'b0;
    logic [1:0] cap_mode = 2'h0;
    logic [31:0] tcount = 32'h0;
    logic [7:0] sfr_rdata, rv;
    logic lfo_osc, lfo_stable, lfo_en, div_clk, dprev;
    logic [3:0] ft;
    logic [2:0] xmode, xfreq;
    logic [1:0] cap;
    logic [31:0] reload, cnt_prev;
    logic [15:0] t3a;
    int err_total = 0;
    int checks_done = 0;
    int caps2 = 0;
    int caps3 = 0;
    int n, n0;

    lxc_top lxc_top_i (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .lfo_osc_in(lfo_osc),
        .lfo_stable_in(lfo_stable), .xosc_stable_in(xosc_stable),
        .lfo_enable(lfo_en), .lfo_fine_tune(ft), .lfo_divided_clk(div_clk),
        .xosc_mode(xmode), .xosc_freq_ctl(xfreq),
        .timer_capture_mode(cap_mode), .timer_count(tcount),
        .timer_capture(cap), .timer_reload(reload));
    lxc_osc_model lxc_osc_model_i (.enable(lfo_en), .settle_ok(settle_ok),
        .osc_out(lfo_osc), .stable(lfo_stable));

    always #2.5 clk = ~clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task final_report;
        $display("Mismatches %0d, checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1;
        sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask : rd

    // Cycles from the previous rising edge of the divided clock
    task wait_rise(output int cyc);
        logic p, q;
        cyc = 0;
        p = div_clk;
        do begin
            @(posedge clk);
            #1;
            cyc++;
            q = p;
            p = div_clk;
        end while (!(p === 1'b1 && q === 1'b0) && cyc < 600);
    endtask : wait_rise

    task poll_ready;
        int k;
        k = 0;
        do begin
            rd(LFO, rv);
            k++;
        end while (rv[6] !== 1'b1 && k < 200);
        chk(rv[6], 1'b1);
    endtask : poll_ready

    // Timer counts move every cycle so a stale copy shows up
    always @(posedge clk) begin
        cnt_prev = tcount;
        dprev = div_clk;
        #1.5;
        if (cap[0] === 1'b1) begin
            caps2++;
            chk(reload[15:0], cnt_prev[15:0]);
            chk({dprev, div_clk}, 2'b10);
        end
        if (cap[1] === 1'b1) begin
            caps3++;
            chk(reload[31:16], cnt_prev[31:16]);
            chk({dprev, div_clk}, 2'b01);
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        fork
            forever @(posedge clk) #1
                tcount = {~tcount[15:0] - 16'h1, tcount[15:0] + 16'h1};
        join_none
        chk({lfo_en, div_clk, cap, xmode, xfreq}, 0);
        chk(ft, lxc_pkg::LXC_FT_RESET);
        rd(LFO, rv);
        chk(rv, {2'b00, lxc_pkg::LXC_FT_RESET, 2'b00});
        rd(XOSC, rv);
        chk(rv, 8'h00);
        wr(LFO, 8'h7c);
        rd(LFO, rv);
        chk(rv, 8'h3c);
        chk(ft, 4'hf);
        wr(LFO, 8'h00);
        chk(ft, 4'h0);
        cap_mode = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            wr(LFO, 8'h80 | 8'(i));
            chk(lfo_en, 1'b1);
            wait_rise(n);
            wait_rise(n);
            wait_rise(n);
            chk(n, 16 << (3 - i));
        end
        chk({caps2 > 0, caps3 > 0}, 2'b11);
        poll_ready;
        settle_ok = 1'b0;
        wr(LFO, 8'h80);
        rd(LFO, rv);
        chk(rv, 8'hc0);
        wr(LFO, 8'h00);
        rd(LFO, rv);
        chk(rv, 8'h40);
        n0 = caps2 + caps3;
        repeat (40) begin
            @(posedge clk);
            #1;
            chk({lfo_osc, div_clk}, 2'b00);
        end
        chk(caps2 + caps3, n0);
        wr(LFO, 8'h01);
        rd(LFO, rv);
        chk(rv, 8'h01);
        settle_ok = 1'b1;
        wr(LFO, 8'h81);
        poll_ready;
        wait_rise(n);
        wait_rise(n);
        chk(n, 64);
        t3a = reload[31:16];
        wait_rise(n);
        chk(16'(t3a - reload[31:16]), 16'h40);
        cap_mode = 2'h0;
        // Let the capture monitor count the pulse of the edge just seen
        #1;
        n0 = caps2 + caps3;
        wait_rise(n);
        wait_rise(n);
        chk(caps2 + caps3, n0);
        xosc_stable = 1'b1;
        for (int m = 0; m < 8; m++) begin
            wr(XOSC, {1'b1, 3'(m), 1'b1, 3'(m) ^ 3'h5});
            repeat (4) @(posedge clk);
            rd(XOSC, rv);
            chk(rv, {m[2], 3'(m), 1'b0, 3'(m) ^ 3'h5});
            chk({xmode, xfreq}, {3'(m), 3'(m) ^ 3'h5});
        end
        xosc_stable = 1'b0;
        repeat (4) @(posedge clk);
        rd(XOSC, rv);
        chk(rv, 8'h72);
        wr(8'h87, 8'hff);
        rd(8'h87, rv);
        chk(rv, 8'h00);
        rd(LFO, rv);
        chk(rv[7:0] & 8'hbf, 8'h81);
        final_report;
    end

    initial begin
        #200000;
        err_total++;
        final_report;
    end
endmodule : lxc_top_tb
`default_nettype wire
